// ### common/tuc_consts.vh
`ifndef TUC_CONSTS_VH
`define TUC_CONSTS_VH

// Register addresses on the byte-wide register port
`define TUC_ADDR_W        4
`define TUC_A_CTRL        4'h0
`define TUC_A_PINFN       4'h1
`define TUC_A_IEN         4'h2
`define TUC_A_STAT        4'h3
`define TUC_A_CNT_H       4'h4
`define TUC_A_CNT_L       4'h5
`define TUC_A_GRA_H       4'h6
`define TUC_A_GRA_L       4'h7
`define TUC_A_GRB_H       4'h8
`define TUC_A_GRB_L       4'h9
`define TUC_A_UNIT        4'ha

// Reset values; reserved bits read as one
`define TUC_RST_CTRL      8'h80
`define TUC_RST_PINFN     8'h88
`define TUC_RST_IEN       8'hf8
`define TUC_RST_STAT      8'hf8
`define TUC_RST_UNIT      8'hce
`define TUC_RST_CNT       16'h0000
`define TUC_RST_GR        16'hffff
`define TUC_CNT_MAX       16'hffff
`define TUC_UNMAPPED      8'h00

// Reserved-bit patterns forced to one on read
`define TUC_RSV_CTRL      8'h80
`define TUC_RSV_PINFN     8'h88
`define TUC_RSV_IRQ       8'hf8
`define TUC_RSV_UNIT      8'hce

// Field positions
`define TUC_F_CLK         2:0
`define TUC_F_EDGE        4:3
`define TUC_F_CLR         6:5
`define TUC_F_FN_A        2:0
`define TUC_F_FN_B        6:4
`define TUC_B_FLAG_A      0
`define TUC_B_FLAG_B      1
`define TUC_B_FLAG_OV     2
`define TUC_B_PHASE       0
`define TUC_F_COMB        5:4

// Clear source codes
`define TUC_CLR_NONE      2'b00
`define TUC_CLR_GRA       2'b01
`define TUC_CLR_GRB       2'b10
`define TUC_CLR_SYNC      2'b11

// Combination mode codes
`define TUC_COMB_CPWM     2'b10
`define TUC_COMB_RPWM     2'b11

// Pin function codes (compare half)
`define TUC_PF_NONE       2'b00
`define TUC_PF_LOW        2'b01
`define TUC_PF_HIGH       2'b10
`define TUC_PF_TOGGLE     2'b11

`endif

// ### rtl/tuc_timer_channel.v
// Contract
// RULE1: Clock select picks prescaled or external source
// RULE2: Edge field chooses rising, falling or both
// RULE3: Clear none, or on register A event
// RULE4: Clear code 10 clears on register B event
// RULE5: Clear code 11 follows synchronized timer clear
// RULE6: Register A compare drives pin per code
// RULE7: Register A captures counter on chosen edges
// RULE8: Register B compare drives pin per code
// RULE9: Register B captures counter on chosen edges
// RULE10: Phase flag selects phase counting on channel
// RULE11: Combination 00/01 keeps channels independent
// RULE12: Combination 10 gives complementary PWM
// RULE13: Combination 11 gives reset-synchronized PWM
// RULE14: Register A interrupt gated by its enable
// RULE15: Register B interrupt gated by its enable
// RULE16: Overflow interrupt gated by its enable
// RULE17: Overflow flag set on wrap to zero
// RULE18: Flag cleared by read-one then write-zero
// RULE19: Code 111 captures both; reserved bits one
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "tuc_consts.vh"

module tuc_timer_channel (
  // Clock and reset
  input  wire                   clk_sys_i,
  input  wire                   srst_i,
  // Register port
  input  wire [`TUC_ADDR_W-1:0] reg_addr_i,
  input  wire [7:0]             reg_wdata_i,
  input  wire                   reg_wr_i,
  input  wire                   reg_rd_i,
  output reg  [7:0]             reg_rdata_o,
  // Pins from outside
  input  wire                   ext_clk_a_i,
  input  wire                   ext_clk_b_i,
  input  wire                   ext_clk_c_i,
  input  wire                   ext_clk_d_i,
  input  wire                   capture_a_i,
  input  wire                   capture_b_i,
  // Synchronized timer clear, same clock domain
  input  wire                   sync_clear_i,
  output reg                    clear_event_o,
  // Compare output pins
  output reg                    compare_a_o,
  output reg                    compare_a_oe_o,
  output reg                    compare_b_o,
  output reg                    compare_b_oe_o,
  // Unit-wide mode status
  output reg                    phase_count_o,
  output reg                    comp_pwm_o,
  output reg                    reset_sync_pwm_o,
  // Interrupts
  output reg                    event_irq_a_o,
  output reg                    event_irq_b_o,
  output reg                    wrap_irq_o,
  output reg                    irq_o
);

  reg  [7:0]  ctrl_ff;
  reg  [7:0]  pinfn_ff;
  reg  [7:0]  ien_ff;
  reg  [7:0]  unit_ff;
  reg  [2:0]  flag_ff;
  reg  [2:0]  armed_ff;
  reg  [15:0] timer_count_ff;
  reg  [15:0] general_reg_a_ff;
  reg  [15:0] general_reg_b_ff;
  reg  [2:0]  div_ff;
  reg  [5:0]  pin_s1_ff;
  reg  [5:0]  pin_s2_ff;
  reg  [5:0]  pin_prev_ff;

  wire [2:0]  clk_sel    = ctrl_ff[`TUC_F_CLK];
  wire [1:0]  edge_sel   = ctrl_ff[`TUC_F_EDGE];
  wire [1:0]  clr_sel    = ctrl_ff[`TUC_F_CLR];
  wire [2:0]  fn_a       = pinfn_ff[`TUC_F_FN_A];
  wire [2:0]  fn_b       = pinfn_ff[`TUC_F_FN_B];
  wire        phase_mode = unit_ff[`TUC_B_PHASE];

  // Pins pass two flops; the third is only history for edges
  wire [5:0]  pin_rise   = pin_s2_ff & ~pin_prev_ff;
  wire [5:0]  pin_fall   = ~pin_s2_ff & pin_prev_ff;

  // Count source
  reg         int_tick;
  reg         ext_rise;
  reg         ext_fall;
  reg         ext_tick;

  always @* begin
    // Free-running divider: the first tick after a switch may come early
    case (clk_sel[1:0])
      2'b00:   int_tick = 1'b1;
      2'b01:   int_tick = div_ff[0];
      2'b10:   int_tick = &div_ff[1:0];
      default: int_tick = &div_ff;
    endcase
    ext_rise = pin_rise[clk_sel[1:0]];
    ext_fall = pin_fall[clk_sel[1:0]];
    if (edge_sel[1]) begin
      ext_tick = ext_rise | ext_fall; // [RULE2]
    end else if (edge_sel[0]) begin
      ext_tick = ext_fall; // [RULE2]
    end else begin
      ext_tick = ext_rise; // [RULE2]
    end
  end

  wire        norm_tick = clk_sel[2] ? ext_tick : int_tick; // [RULE1]

  // Quadrature decode on external clocks A and B
  wire        qa_cur    = pin_s2_ff[0];
  wire        qb_cur    = pin_s2_ff[1];
  wire        qa_old    = pin_prev_ff[0];
  wire        qb_old    = pin_prev_ff[1];
  // A step where both inputs moved is dropped, not guessed
  wire        q_moved   = (qa_cur ^ qa_old) | (qb_cur ^ qb_old);
  wire        q_up      = q_moved & (qa_cur ^ qb_old);
  wire        q_down    = q_moved & (qa_old ^ qb_cur);

  wire        cnt_up    = phase_mode ? (q_up & ~q_down) : norm_tick; // [RULE10]
  wire        cnt_down  = phase_mode & q_down & ~q_up; // [RULE10]

  // Capture edge select; code 111 behaves as 110
  function cap_hit;
    input [1:0] mode;
    input       rise;
    input       fall;
    begin
      if (mode[1]) begin
        cap_hit = rise | fall; // [RULE19]
      end else if (mode[0]) begin
        cap_hit = fall;
      end else begin
        cap_hit = rise;
      end
    end
  endfunction

  wire        cap_a   = fn_a[2] & cap_hit(fn_a[1:0], pin_rise[4], pin_fall[4]); // [RULE7]
  wire        cap_b   = fn_b[2] & cap_hit(fn_b[1:0], pin_rise[5], pin_fall[5]); // [RULE9]
  // Match is taken when the counter advances off the equal value
  wire        match_a = ~fn_a[2] & cnt_up & (timer_count_ff == general_reg_a_ff); // [RULE6]
  wire        match_b = ~fn_b[2] & cnt_up & (timer_count_ff == general_reg_b_ff); // [RULE8]
  wire        ev_a    = cap_a | match_a;
  wire        ev_b    = cap_b | match_b;
  wire        wrap    = cnt_up & (timer_count_ff == `TUC_CNT_MAX); // [RULE17]

  reg         clr_hit;

  always @* begin
    case (clr_sel)
      `TUC_CLR_GRA:  clr_hit = ev_a; // [RULE3]
      `TUC_CLR_GRB:  clr_hit = ev_b; // [RULE4]
      `TUC_CLR_SYNC: clr_hit = sync_clear_i; // [RULE5]
      default:       clr_hit = 1'b0; // [RULE3]
    endcase
  end

  // Write decodes
  wire        wr_ctrl  = reg_wr_i & (reg_addr_i == `TUC_A_CTRL);
  wire        wr_pinfn = reg_wr_i & (reg_addr_i == `TUC_A_PINFN);
  wire        wr_ien   = reg_wr_i & (reg_addr_i == `TUC_A_IEN);
  wire        wr_unit  = reg_wr_i & (reg_addr_i == `TUC_A_UNIT);
  wire        wr_gra_h = reg_wr_i & (reg_addr_i == `TUC_A_GRA_H);
  wire        wr_gra_l = reg_wr_i & (reg_addr_i == `TUC_A_GRA_L);
  wire        wr_grb_h = reg_wr_i & (reg_addr_i == `TUC_A_GRB_H);
  wire        wr_grb_l = reg_wr_i & (reg_addr_i == `TUC_A_GRB_L);
  wire        wr_cnt_h = reg_wr_i & (reg_addr_i == `TUC_A_CNT_H);
  wire        wr_cnt_l = reg_wr_i & (reg_addr_i == `TUC_A_CNT_L);
  wire        wr_stat  = reg_wr_i & (reg_addr_i == `TUC_A_STAT);
  wire        rd_stat  = reg_rd_i & (reg_addr_i == `TUC_A_STAT);
  wire [2:0]  ev_vec   = {wrap, ev_b, ev_a};

  reg  [15:0] nxt_timer_count;
  reg  [2:0]  nxt_flag;
  reg  [2:0]  nxt_armed;

  always @* begin
    nxt_timer_count = timer_count_ff;
    if (clr_hit) begin
      nxt_timer_count = `TUC_RST_CNT;
    end else if (cnt_up) begin
      nxt_timer_count = timer_count_ff + 16'h0001;
    end else if (cnt_down) begin
      nxt_timer_count = timer_count_ff - 16'h0001;
    end
    // Software write wins over counting
    if (wr_cnt_h) begin
      nxt_timer_count[15:8] = reg_wdata_i;
    end
    if (wr_cnt_l) begin
      nxt_timer_count[7:0] = reg_wdata_i;
    end
    // A read seeing one arms the clear; the next status write disarms every bit
    nxt_armed = armed_ff;
    nxt_flag  = flag_ff;
    if (wr_stat) begin
      nxt_flag  = flag_ff & ~(armed_ff & ~reg_wdata_i[2:0]); // [RULE18]
      nxt_armed = 3'h0;
    end
    if (rd_stat) begin
      nxt_armed = flag_ff; // [RULE18]
    end
    // A new event beats a clear in the same cycle
    nxt_flag = nxt_flag | ev_vec; // [RULE17]
  end

  // Compare pin action
  function pin_act;
    input [1:0] code;
    input       cur;
    begin
      case (code)
        `TUC_PF_LOW:    pin_act = 1'b0;
        `TUC_PF_HIGH:   pin_act = 1'b1;
        `TUC_PF_TOGGLE: pin_act = ~cur;
        default:        pin_act = cur;
      endcase
    end
  endfunction

  wire [7:0]  irq_bits = flag_ff & ien_ff;
  wire [2:0]  irq_now  = {irq_bits[`TUC_B_FLAG_OV], irq_bits[`TUC_B_FLAG_B],
                          irq_bits[`TUC_B_FLAG_A]};

  reg  [7:0]  nxt_rdata;

  always @* begin
    case (reg_addr_i)
      `TUC_A_CTRL:  nxt_rdata = ctrl_ff | `TUC_RSV_CTRL; // [RULE19]
      `TUC_A_PINFN: nxt_rdata = pinfn_ff | `TUC_RSV_PINFN; // [RULE19]
      `TUC_A_IEN:   nxt_rdata = ien_ff | `TUC_RSV_IRQ;
      `TUC_A_STAT:  nxt_rdata = {5'h1f, flag_ff};
      `TUC_A_CNT_H: nxt_rdata = timer_count_ff[15:8];
      `TUC_A_CNT_L: nxt_rdata = timer_count_ff[7:0];
      `TUC_A_GRA_H: nxt_rdata = general_reg_a_ff[15:8];
      `TUC_A_GRA_L: nxt_rdata = general_reg_a_ff[7:0];
      `TUC_A_GRB_H: nxt_rdata = general_reg_b_ff[15:8];
      `TUC_A_GRB_L: nxt_rdata = general_reg_b_ff[7:0];
      `TUC_A_UNIT:  nxt_rdata = unit_ff | `TUC_RSV_UNIT;
      default:      nxt_rdata = `TUC_UNMAPPED;
    endcase
  end

  // Runs through reset so the history matches the pin: no false edge after it
  always @(posedge clk_sys_i) begin
    pin_s1_ff   <= {capture_b_i, capture_a_i, ext_clk_d_i, ext_clk_c_i,
                    ext_clk_b_i, ext_clk_a_i};
    pin_s2_ff   <= pin_s1_ff;
    pin_prev_ff <= pin_s2_ff;
  end

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      ctrl_ff          <= `TUC_RST_CTRL;
      pinfn_ff         <= `TUC_RST_PINFN;
      ien_ff           <= `TUC_RST_IEN;
      unit_ff          <= `TUC_RST_UNIT;
      flag_ff          <= 3'h0;
      armed_ff         <= 3'h0;
      timer_count_ff   <= `TUC_RST_CNT;
      general_reg_a_ff <= `TUC_RST_GR;
      general_reg_b_ff <= `TUC_RST_GR;
      div_ff           <= 3'h0;
      reg_rdata_o      <= 8'h00;
      clear_event_o    <= 1'b0;
      compare_a_o      <= 1'b0;
      compare_a_oe_o   <= 1'b0;
      compare_b_o      <= 1'b0;
      compare_b_oe_o   <= 1'b0;
      phase_count_o    <= 1'b0;
      comp_pwm_o       <= 1'b0;
      reset_sync_pwm_o <= 1'b0;
      event_irq_a_o    <= 1'b0;
      event_irq_b_o    <= 1'b0;
      wrap_irq_o       <= 1'b0;
      irq_o            <= 1'b0;
    end else begin
      div_ff      <= div_ff + 3'h1;

      // Reserved bits keep their ones whatever is written
      if (wr_ctrl) begin
        ctrl_ff <= reg_wdata_i | `TUC_RSV_CTRL; // [RULE19]
      end
      if (wr_pinfn) begin
        pinfn_ff <= reg_wdata_i | `TUC_RSV_PINFN; // [RULE19]
      end
      if (wr_ien) begin
        ien_ff <= reg_wdata_i | `TUC_RSV_IRQ;
      end
      if (wr_unit) begin
        unit_ff <= reg_wdata_i | `TUC_RSV_UNIT;
      end

      // Capture beats a software write to the same register
      if (cap_a) begin
        general_reg_a_ff <= timer_count_ff; // [RULE7]
      end else if (wr_gra_h) begin
        general_reg_a_ff[15:8] <= reg_wdata_i;
      end else if (wr_gra_l) begin
        general_reg_a_ff[7:0] <= reg_wdata_i;
      end
      if (cap_b) begin
        general_reg_b_ff <= timer_count_ff; // [RULE9]
      end else if (wr_grb_h) begin
        general_reg_b_ff[15:8] <= reg_wdata_i;
      end else if (wr_grb_l) begin
        general_reg_b_ff[7:0] <= reg_wdata_i;
      end

      timer_count_ff <= nxt_timer_count;
      flag_ff        <= nxt_flag;
      armed_ff       <= nxt_armed;
      reg_rdata_o    <= reg_rd_i ? nxt_rdata : 8'h00;
      clear_event_o  <= clr_hit;

      // Pin is driven only while the register compares
      compare_a_oe_o <= ~fn_a[2];
      compare_b_oe_o <= ~fn_b[2];
      if (match_a) begin
        compare_a_o <= pin_act(fn_a[1:0], compare_a_o); // [RULE6]
      end
      if (match_b) begin
        compare_b_o <= pin_act(fn_b[1:0], compare_b_o); // [RULE8]
      end

      phase_count_o    <= phase_mode; // [RULE10]
      // Codes 00 and 01 leave both joint modes off
      comp_pwm_o       <= (unit_ff[`TUC_F_COMB] == `TUC_COMB_CPWM); // [RULE11] [RULE12]
      reset_sync_pwm_o <= (unit_ff[`TUC_F_COMB] == `TUC_COMB_RPWM); // [RULE11] [RULE13]

      event_irq_a_o <= irq_now[0]; // [RULE14]
      event_irq_b_o <= irq_now[1]; // [RULE15]
      wrap_irq_o    <= irq_now[2]; // [RULE16]
      irq_o         <= |irq_now;
    end
  end

endmodule // tuc_timer_channel
`default_nettype wire

// ### testbench/tuc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module tuc_pin_model (
  // Clock
  input  wire logic       clk_sys_i,
  // Pins toward the timer
  output var  logic [3:0] ext_clk_o,
  output var  logic [1:0] capture_o
);
  initial begin
    ext_clk_o = 4'h0;
    capture_o = 2'h0;
  end
  // Each level held 5 cycles so the synchronizer sees every edge
  task automatic drive_clk(input logic [3:0] m);
    ext_clk_o <= m;
    repeat (5) @(posedge clk_sys_i);
  endtask
  task automatic drive_cap(input logic [1:0] m);
    capture_o <= m;
    repeat (5) @(posedge clk_sys_i);
  endtask
endmodule // tuc_pin_model
`default_nettype wire

// ### testbench/tuc_timer_channel_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "tuc_consts.vh"
module tuc_timer_channel_chk (
  // Clock and reset
  input wire logic                   clk_sys_i,
  input wire logic                   srst_i,
  // Register port
  input wire logic [`TUC_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0]             reg_wdata_i,
  input wire logic                   reg_wr_i,
  input wire logic                   reg_rd_i,
  input wire logic [7:0]             reg_rdata_o,
  // Observed outputs
  input wire logic                   compare_a_oe_o,
  input wire logic                   compare_b_oe_o,
  input wire logic                   phase_count_o,
  input wire logic                   comp_pwm_o,
  input wire logic                   reset_sync_pwm_o,
  input wire logic                   event_irq_a_o,
  input wire logic                   event_irq_b_o,
  input wire logic                   wrap_irq_o,
  input wire logic                   irq_o
);
  logic [1:0] rst_ff;
  logic [7:0] ien_ff;
  logic [7:0] pin_ff;
  logic [7:0] unit_ff;
  // Shadows so the first edge after release is never judged
  always_ff @(posedge clk_sys_i) begin
    rst_ff <= {rst_ff[0], srst_i};
    if (srst_i) begin
      ien_ff <= 8'h00;
      pin_ff <= 8'h00;
      unit_ff <= 8'h00;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `TUC_A_IEN) ien_ff <= reg_wdata_i;
      if (reg_addr_i == `TUC_A_PINFN) pin_ff <= reg_wdata_i;
      if (reg_addr_i == `TUC_A_UNIT) unit_ff <= reg_wdata_i;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i || (|rst_ff));
  irq_quiet_a: assert property ((!event_irq_a_o && !event_irq_b_o && !wrap_irq_o) [*2]
    |-> !irq_o) else $error("irq high without source");
  rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside read slot");
  irq_a_gate_a: assert property (event_irq_a_o |-> $past(ien_ff[0]))
    else $error("irq a while disabled");
  irq_b_gate_a: assert property (event_irq_b_o |-> $past(ien_ff[1]))
    else $error("irq b while disabled");
  wrap_gate_a: assert property (wrap_irq_o |-> $past(ien_ff[2]))
    else $error("wrap irq while disabled");
  oe_a_mode_a: assert property (compare_a_oe_o == !$past(pin_ff[2]))
    else $error("pin a enable wrong");
  oe_b_mode_a: assert property (compare_b_oe_o == !$past(pin_ff[6]))
    else $error("pin b enable wrong");
  phase_flag_a: assert property (phase_count_o == $past(unit_ff[0]))
    else $error("phase flag wrong");
  cpwm_mode_a: assert property (comp_pwm_o == ($past(unit_ff[5:4]) == `TUC_COMB_CPWM))
    else $error("complementary mode wrong");
  rpwm_mode_a: assert property (reset_sync_pwm_o == ($past(unit_ff[5:4]) == `TUC_COMB_RPWM))
    else $error("reset sync mode wrong");
endmodule // tuc_timer_channel_chk
bind tuc_timer_channel tuc_timer_channel_chk u_tuc_timer_channel_chk (
  .clk_sys_i(clk_sys_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .compare_a_oe_o(compare_a_oe_o), .compare_b_oe_o(compare_b_oe_o),
  .phase_count_o(phase_count_o), .comp_pwm_o(comp_pwm_o), .reset_sync_pwm_o(reset_sync_pwm_o),
  .event_irq_a_o(event_irq_a_o), .event_irq_b_o(event_irq_b_o), .wrap_irq_o(wrap_irq_o),
  .irq_o(irq_o));
`default_nettype wire

// ### testbench/tb_tuc_timer_channel.sv
`timescale 1ns/1ps
`default_nettype none
`include "tuc_consts.vh"
module tb_tuc_timer_channel;
  logic                   clk_sys_i, srst_i, reg_wr_i, reg_rd_i, sync_clear_i, rd_seen;
  logic [`TUC_ADDR_W-1:0] reg_addr_i, gr;
  logic [7:0]             reg_wdata_i, reg_rdata_o;
  logic [7:0]             exp_q[$];
  logic [3:0]             ext_clk;
  logic [1:0]             cap;
  logic [15:0]            v, v2;
  logic                   clear_event_o, compare_a_o, compare_a_oe_o, compare_b_o;
  logic                   compare_b_oe_o, phase_count_o, comp_pwm_o, reset_sync_pwm_o;
  logic                   event_irq_a_o, event_irq_b_o, wrap_irq_o, irq_o;
  int                     error_cnt, total_checks, n, e, k, s, gap;
  tuc_timer_channel u_tuc_timer_channel (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .ext_clk_a_i(ext_clk[0]), .ext_clk_b_i(ext_clk[1]),
    .ext_clk_c_i(ext_clk[2]), .ext_clk_d_i(ext_clk[3]), .capture_a_i(cap[0]),
    .capture_b_i(cap[1]), .sync_clear_i(sync_clear_i), .clear_event_o(clear_event_o),
    .compare_a_o(compare_a_o), .compare_a_oe_o(compare_a_oe_o), .compare_b_o(compare_b_o),
    .compare_b_oe_o(compare_b_oe_o), .phase_count_o(phase_count_o), .comp_pwm_o(comp_pwm_o),
    .reset_sync_pwm_o(reset_sync_pwm_o), .event_irq_a_o(event_irq_a_o),
    .event_irq_b_o(event_irq_b_o), .wrap_irq_o(wrap_irq_o), .irq_o(irq_o));
  tuc_pin_model u_tuc_pin_model (.clk_sys_i(clk_sys_i), .ext_clk_o(ext_clk), .capture_o(cap));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One call per edge, so back-to-back strobes never double-assign
  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= w;
    reg_rd_i <= r;
    reg_addr_i <= a;
    reg_wdata_i <= d;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic idle(input int c);
    repeat (c) bus(1'b0, 1'b0, 4'h0, 8'h00);
  endtask
  task automatic pins(input logic [3:0] m);
    idle(1);
    u_tuc_pin_model.drive_clk(m);
  endtask
  task automatic caps(input logic [1:0] m);
    idle(1);
    u_tuc_pin_model.drive_cap(m);
  endtask
  task automatic gap_of(output int g);
    logic lv;
    @(negedge clk_sys_i);
    lv = compare_a_o;
    for (g = 0; g < 200 && compare_a_o === lv; g++) @(negedge clk_sys_i);
    lv = compare_a_o;
    for (g = 0; g < 200 && compare_a_o === lv; g++) @(negedge clk_sys_i);
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #200000;
    error_cnt++;
    wrap_up();
  end
  always @(posedge clk_sys_i) rd_seen <= reg_rd_i;
  always @(negedge clk_sys_i) if (rd_seen === 1'b1) check(reg_rdata_o, exp_q.pop_front());
  initial begin
    {srst_i, reg_wr_i, reg_rd_i, sync_clear_i} = 4'b1000;
    reg_addr_i = 4'h0;
    reg_wdata_i = 8'h00;
    error_cnt = 0;
    total_checks = 0;
    void'($urandom(7));
    repeat (16) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    rd(`TUC_A_CTRL, 8'h80);
    rd(`TUC_A_PINFN, 8'h88);
    rd(`TUC_A_IEN, 8'hf8);
    rd(`TUC_A_STAT, 8'hf8);
    rd(`TUC_A_GRA_H, 8'hff);
    rd(`TUC_A_UNIT, `TUC_RST_UNIT);
    rd(4'hb, 8'h00);
    // Freeze on an idle pin before loading the compare setup
    wr(`TUC_A_CTRL, 8'h04);
    wr(`TUC_A_GRA_H, 8'h00);
    wr(`TUC_A_GRA_L, 8'h05);
    wr(`TUC_A_CNT_H, 8'h00);
    wr(`TUC_A_CNT_L, 8'h00);
    wr(`TUC_A_PINFN, 8'h03);
    wr(`TUC_A_IEN, 8'h01);
    for (k = 0; k < 4; k++) begin
      wr(`TUC_A_CTRL, 8'h20 | k[7:0]);
      idle(1);
      gap_of(gap);
      check(gap[7:0], 8'h06 << k);
    end
    check(event_irq_a_o, 1'b1);
    wr(`TUC_A_CTRL, 8'h04);
    wr(`TUC_A_IEN, 8'h00);
    idle(3);
    @(negedge clk_sys_i);
    check({event_irq_a_o, irq_o}, 2'b00);
    wr(`TUC_A_IEN, 8'h01);
    rd(`TUC_A_STAT, 8'hf9);
    wr(`TUC_A_STAT, 8'hff);
    rd(`TUC_A_STAT, 8'hf9);
    idle(2);
    @(negedge clk_sys_i);
    check(irq_o, 1'b1);
    wr(`TUC_A_STAT, 8'hf8);
    rd(`TUC_A_STAT, 8'hf8);
    idle(3);
    @(negedge clk_sys_i);
    check(irq_o, 1'b0);
    // Selected pin gets one pulse fewer than the others
    for (k = 0; k < 4; k++) begin
      e = $urandom % 4;
      n = 1 + $urandom % 4;
      wr(`TUC_A_CTRL, {3'b000, e[1:0], 1'b1, k[1:0]});
      wr(`TUC_A_CNT_L, 8'h00);
      for (s = 0; s <= n; s++) begin
        pins(s < n ? 4'hf : ~(4'h1 << k));
        pins(4'h0);
      end
      pins(4'hf);
      rd(`TUC_A_CNT_L, 8'(e > 1 ? 2 * n + 1 : n + (e == 0 ? 1 : 0)));
      pins(4'h0);
    end
    wr(`TUC_A_IEN, 8'h03);
    for (s = 0; s < 2; s++) begin
      for (k = 4; k < 8; k++) begin
        gr = s ? `TUC_A_GRB_L : `TUC_A_GRA_L;
        v = 16'($urandom);
        v2 = 16'($urandom);
        wr(`TUC_A_CTRL, s ? 8'h44 : 8'h24);
        wr(`TUC_A_PINFN, s ? 8'(k << 4) : 8'(k));
        wr(gr, 8'h00);
        wr(`TUC_A_CNT_L, v[7:0]);
        caps(2'b01 << s);
        rd(`TUC_A_STAT, k == 5 ? 8'hf8 : 8'hf8 | (8'h01 << s));
        rd(gr, k == 5 ? 8'h00 : v[7:0]);
        rd(`TUC_A_CNT_L, k == 5 ? v[7:0] : 8'h00);
        wr(`TUC_A_STAT, 8'hf8);
        wr(`TUC_A_CNT_L, v2[7:0]);
        caps(2'b00);
        rd(`TUC_A_STAT, k == 4 ? 8'hf8 : 8'hf8 | (8'h01 << s));
        rd(gr, k == 4 ? v[7:0] : v2[7:0]);
        rd(`TUC_A_CNT_L, k == 4 ? v2[7:0] : 8'h00);
        wr(`TUC_A_STAT, 8'hf8);
      end
    end
    for (k = 0; k < 4; k += 3) begin
      wr(`TUC_A_CTRL, {1'b0, k[1:0], 5'h04});
      wr(`TUC_A_CNT_L, 8'h55);
      idle(1);
      sync_clear_i <= 1'b1;
      idle(1);
      sync_clear_i <= 1'b0;
      @(negedge clk_sys_i);
      check(clear_event_o, k == 3);
      rd(`TUC_A_CNT_L, k == 3 ? 8'h00 : 8'h55);
    end
    // Register B drives its pin high on the way up to the wrap
    wr(`TUC_A_PINFN, 8'h24);
    wr(`TUC_A_GRB_H, 8'hff);
    wr(`TUC_A_GRB_L, 8'hf8);
    wr(`TUC_A_IEN, 8'h00);
    wr(`TUC_A_CNT_L, 8'hf0);
    wr(`TUC_A_CNT_H, 8'hff);
    wr(`TUC_A_CTRL, 8'h00);
    idle(40);
    @(negedge clk_sys_i);
    check({wrap_irq_o, irq_o}, 2'b00);
    check(compare_b_o, 1'b1);
    rd(`TUC_A_STAT, 8'hfe);
    wr(`TUC_A_IEN, 8'h04);
    idle(3);
    @(negedge clk_sys_i);
    check({wrap_irq_o, irq_o, event_irq_b_o}, 3'b110);
    for (k = 0; k < 4; k++) begin
      e = $urandom % 2;
      wr(`TUC_A_UNIT, {2'b00, k[1:0], 3'b000, e[0]});
      rd(`TUC_A_UNIT, `TUC_RST_UNIT | {2'b00, k[1:0], 3'b000, e[0]});
      idle(2);
      @(negedge clk_sys_i);
      check({comp_pwm_o, reset_sync_pwm_o, phase_count_o}, {k == 2, k == 3, e[0]});
    end
    // Gray steps on pins A and B: three up, then one back down
    wr(`TUC_A_UNIT, 8'h01);
    wr(`TUC_A_CNT_L, 8'h00);
    pins(4'h1);
    pins(4'h3);
    pins(4'h2);
    pins(4'h3);
    rd(`TUC_A_CNT_L, 8'h02);
    idle(3);
    wrap_up();
  end
endmodule // tb_tuc_timer_channel
`default_nettype wire
